// ### logic/dftt_pkg.sv
// Package for the rear window heater toggle timer
package dftt_pkg;
	// Timing in own units
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned LONG_MIN      = 10;
	localparam int unsigned SHORT_MIN     = 5;
	localparam int unsigned DEBOUNCE_MS   = 20;
	// Derived counts
	localparam int unsigned TICK_HZ       = 1000;
	localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
	localparam int unsigned LONG_TICKS    = LONG_MIN * 60 * TICK_HZ;
	localparam int unsigned SHORT_TICKS   = SHORT_MIN * 60 * TICK_HZ;
	localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS * TICK_HZ / 1000;
	localparam int unsigned TMR_W         = 20;
	localparam int unsigned DB_W          = 8;

	// Heater state
	typedef enum logic [1:0] {
		DFTT_OFF,
		DFTT_LONG,
		DFTT_SHORT
	} dftt_state_e;

	// Debounced switch view
	typedef struct packed {
		logic level;
		logic press;
	} dftt_sw_s;
endpackage : dftt_pkg

// ### logic/dftt_debounce.sv
// Switch debouncer producing one press pulse per stable grounding
`timescale 1ns/1ps
`default_nettype none
module dftt_debounce #(
	parameter int unsigned DB_TICKS = dftt_pkg::DEBOUNCE_TICKS
) (
	// Clock, reset and millisecond tick enable
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              tick,
	// Raw switch, active low
	input  wire logic              sw_sense_n,
	// Filtered view
	output dftt_pkg::dftt_sw_s     sw
);
	import dftt_pkg::*;

	// Refuse a quiet time the counter cannot hold
	if (DB_TICKS < 1 || DB_TICKS >= (1 << DB_W)) begin : g_bad_db
		$error("DB_TICKS out of range");
	end

	logic            stable_r, stable_nxt;
	logic            press_r, press_nxt;
	logic [DB_W-1:0] cnt_r, cnt_nxt;

	always_comb begin
		stable_nxt = stable_r;
		cnt_nxt    = cnt_r;
		press_nxt  = 1'b0;
		if (~sw_sense_n == stable_r) begin
			cnt_nxt = '0;
		end else if (tick) begin
			if (cnt_r == DB_W'(DB_TICKS - 1)) begin
				// Accept new level only after full quiet time
				stable_nxt = ~sw_sense_n;
				cnt_nxt    = '0;
				press_nxt  = ~sw_sense_n;
			end else begin
				cnt_nxt = cnt_r + DB_W'(1);
			end
		end
	end

	// Filter registers
	always_ff @(posedge clock) begin
		if (reset) begin
			stable_r <= 1'b0;
			press_r  <= 1'b0;
			cnt_r    <= '0;
		end else begin
			stable_r <= stable_nxt;
			press_r  <= press_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

	assign sw.level = stable_r;
	assign sw.press = press_r;

	AST_PRESS_SINGLE: assert property (@(posedge clock) disable iff (reset)
		press_r |=> !press_r) else $error("press pulse longer than one cycle");
	AST_PRESS_LEVEL: assert property (@(posedge clock) disable iff (reset)
		press_r |-> stable_r) else $error("press without settled grounding");
	AST_LEVEL_TICK: assert property (@(posedge clock) disable iff (reset)
		!tick |=> $stable(stable_r)) else $error("filtered level moved between ticks");
endmodule : dftt_debounce
`default_nettype wire

// ### logic/dftt_top.sv
// Rear window heater toggle timer top level
// Timing base is a millisecond enable, so intervals end within one tick of nominal.
// A manual switch-off does not spend the long interval; only a timeout does.
// Ignition Off wins over a press and over a timeout landing in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module dftt_top #(
	parameter int unsigned TICK_DIV    = dftt_pkg::TICK_DIV,
	parameter int unsigned LONG_TICKS  = dftt_pkg::LONG_TICKS,
	parameter int unsigned SHORT_TICKS = dftt_pkg::SHORT_TICKS,
	parameter int unsigned DB_TICKS    = dftt_pkg::DEBOUNCE_TICKS
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset,
	// Vehicle inputs
	input  wire logic sw_sense_n,
	input  wire logic ignition_on,
	// Relay coil sink, active low
	output logic      relay_sink_n,
	// Status
	output logic      heater_on,
	output logic      long_used
);
	import dftt_pkg::*;

	// Width of the millisecond divider count
	localparam int unsigned DIV_W = 16;

	// Refuse a divider the count cannot reach
	if (TICK_DIV < 2 || TICK_DIV >= (1 << DIV_W)) begin : g_bad_div
		$error("TICK_DIV out of range");
	end
	// Short must not outlast long, and long must fit the timer
	if (SHORT_TICKS < 1 || SHORT_TICKS > LONG_TICKS ||
		LONG_TICKS >= (1 << TMR_W)) begin : g_bad_tmr
		$error("timeout counts out of range");
	end

	logic [DIV_W-1:0] div_r, div_nxt;
	logic             tick;
	dftt_state_e      state_r, state_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic             used_r, used_nxt;
	logic             ign_r;
	logic             sink_n_r, sink_n_nxt;
	logic [TMR_W-1:0] on_ticks_r, on_ticks_nxt;
	dftt_sw_s         sw;

	// Interval loaded at switch-on; the long one only until it has expired once
	function automatic logic [TMR_W-1:0] interval_ticks(input logic long_spent);
		return long_spent ? TMR_W'(SHORT_TICKS) : TMR_W'(LONG_TICKS);
	endfunction : interval_ticks

	// Millisecond enable divider
	always_comb begin
		tick    = (div_r == DIV_W'(TICK_DIV - 1));
		div_nxt = tick ? '0 : div_r + DIV_W'(1);
	end

	always_ff @(posedge clock) begin
		if (reset)
			div_r <= '0;
		else
			div_r <= div_nxt;
	end

	// Debounced switch
	dftt_debounce #(
		.DB_TICKS (DB_TICKS)
	) u_debounce (
		.clock      (clock),
		.reset      (reset),
		.tick       (tick),
		.sw_sense_n (sw_sense_n),
		.sw         (sw)
	);

	// Heater state and timeout
	always_comb begin
		state_nxt = state_r;
		tmr_nxt   = tmr_r;
		used_nxt  = used_r;
		case (state_r)
			DFTT_OFF: begin
				if (ignition_on && sw.press) begin
					state_nxt = used_r ? DFTT_SHORT : DFTT_LONG;
					tmr_nxt   = interval_ticks(used_r);
				end
			end
			DFTT_LONG, DFTT_SHORT: begin
				if (sw.press) begin
					state_nxt = DFTT_OFF;
				end else if (tick) begin
					if (tmr_r == TMR_W'(1)) begin
						state_nxt = DFTT_OFF;
						used_nxt  = 1'b1;
					end else begin
						tmr_nxt = tmr_r - TMR_W'(1);
					end
				end
			end
			default: state_nxt = DFTT_OFF;
		endcase
		if (!ignition_on) begin
			state_nxt = DFTT_OFF;
			// Long interval returns on the next ignition cycle
			used_nxt  = 1'b0;
		end
		sink_n_nxt = (state_nxt == DFTT_OFF);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r  <= DFTT_OFF;
			tmr_r    <= '0;
			used_r   <= 1'b0;
			ign_r    <= 1'b0;
			sink_n_r <= 1'b1;
		end else begin
			state_r  <= state_nxt;
			tmr_r    <= tmr_nxt;
			used_r   <= used_nxt;
			ign_r    <= ignition_on;
			sink_n_r <= sink_n_nxt;
		end
	end

	assign relay_sink_n = sink_n_r;
	assign heater_on    = (state_r != DFTT_OFF);
	assign long_used    = used_r;

	// Assertion helper: ticks spent on since switch-on, kept apart from the timer
	always_comb begin
		on_ticks_nxt = on_ticks_r;
		if (!heater_on) begin
			on_ticks_nxt = '0;
		end else if (tick) begin
			on_ticks_nxt = on_ticks_r + TMR_W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			on_ticks_r <= '0;
		else
			on_ticks_r <= on_ticks_nxt;
	end

	// Assertions on the output and the switch
	// sink follows state
	AST_OUT_MATCH: assert property (@(posedge clock) disable iff (reset)
		relay_sink_n == !heater_on) else $error("sink not tied to state");
	AST_IGN_OFF: assert property (@(posedge clock) disable iff (reset)
		!ignition_on |=> relay_sink_n) else $error("heater on with ignition off");
	AST_IGN_GATE: assert property (@(posedge clock) disable iff (reset)
		(!heater_on && !ignition_on) |=> !heater_on) else $error("turned on without ignition");
	AST_TOGGLE_ON: assert property (@(posedge clock) disable iff (reset)
		(!heater_on && ignition_on && sw.press) |=> heater_on) else $error("press missed on");
	AST_TOGGLE_OFF: assert property (@(posedge clock) disable iff (reset)
		(heater_on && sw.press) |=> !heater_on) else $error("press missed off");
	AST_OFF_HOLD: assert property (@(posedge clock) disable iff (reset)
		(!heater_on && !sw.press) |=> !heater_on) else $error("turned on without press");

	// Assertions on the intervals
	// long first
	AST_LONG_FIRST: assert property (@(posedge clock) disable iff (reset)
		(!heater_on && ignition_on && sw.press && !used_r) |=>
		(state_r == DFTT_LONG && tmr_r == TMR_W'(LONG_TICKS))) else $error("first not long");
	AST_SHORT_LATER: assert property (@(posedge clock) disable iff (reset)
		(!heater_on && ignition_on && sw.press && used_r) |=>
		(state_r == DFTT_SHORT && tmr_r == TMR_W'(SHORT_TICKS))) else $error("later not short");
	AST_TIMEOUT: assert property (@(posedge clock) disable iff (reset)
		(heater_on && ignition_on && !sw.press && tick && tmr_r == TMR_W'(1)) |=>
		(!heater_on && used_r)) else $error("timeout not taken");
	AST_TMR_HOLD: assert property (@(posedge clock) disable iff (reset)
		(heater_on && ignition_on && !sw.press && !tick) |=> (heater_on && $stable(tmr_r)))
		else $error("timer moved between ticks");
	AST_TMR_LIVE: assert property (@(posedge clock) disable iff (reset)
		heater_on |-> (tmr_r != '0)) else $error("timer empty while on");
	AST_LONG_SPAN: assert property (@(posedge clock) disable iff (reset)
		(state_r == DFTT_LONG) |-> (tmr_r + on_ticks_r == TMR_W'(LONG_TICKS)))
		else $error("long interval miscounted");
	AST_SHORT_SPAN: assert property (@(posedge clock) disable iff (reset)
		(state_r == DFTT_SHORT) |-> (tmr_r + on_ticks_r == TMR_W'(SHORT_TICKS)))
		else $error("short interval miscounted");
	AST_USED_RISE: assert property (@(posedge clock) disable iff (reset)
		(!used_r && !(heater_on && tick && tmr_r == TMR_W'(1))) |=> !used_r)
		else $error("long interval spent without timeout");
	AST_USED_CLEAR: assert property (@(posedge clock) disable iff (reset)
		(ign_r && !ignition_on) |=> !used_r) else $error("long interval not restored");

	// Assertions on the time base
	// tick single cycle
	AST_TICK_PULSE: assert property (@(posedge clock) disable iff (reset)
		tick |=> !tick) else $error("tick longer than one cycle");
	AST_DIV_RANGE: assert property (@(posedge clock) disable iff (reset)
		div_r <= DIV_W'(TICK_DIV - 1)) else $error("divider past its end");
endmodule : dftt_top
`default_nettype wire

// ### dv/dftt_switch_model.sv
// Switch and relay coil model for the heater timer
`timescale 1ns/1ps
`default_nettype none
module dftt_switch_model (
	// Operator side
	input  wire logic push,
	// Device side
	output logic      sw_sense_n,
	input  wire logic relay_sink_n,
	output logic      coil_on
);
	// Pressing grounds the sense line
	assign sw_sense_n = ~push;
	assign coil_on = ~relay_sink_n;
endmodule : dftt_switch_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the heater toggle timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic push = 1'b0;
	logic ignition_on = 1'b0;
	logic sw_sense_n, relay_sink_n, heater_on, long_used, coil_on;
	int   n_fail = 0;
	int   comparisons = 0;
	// 20 MHz clock
	always #25 clock = ~clock;
	// Short counts keep timeouts under a hundred cycles
	dftt_top #(.TICK_DIV(4), .LONG_TICKS(20), .SHORT_TICKS(10), .DB_TICKS(2)) dftt_top_i (
		.clock(clock), .reset(reset), .sw_sense_n(sw_sense_n), .ignition_on(ignition_on),
		.relay_sink_n(relay_sink_n), .heater_on(heater_on), .long_used(long_used));
	dftt_switch_model dftt_switch_model_i (.push(push), .sw_sense_n(sw_sense_n),
		.relay_sink_n(relay_sink_n), .coil_on(coil_on));
	task automatic chk(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk
	// Heater flag, coil and sink must agree
	task automatic chk_out(input logic exp);
		chk("heater_on", exp, heater_on);
		chk("coil_on", exp, coil_on);
		chk("relay_sink_n", ~exp, relay_sink_n);
	endtask : chk_out
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	// Hold switch until heater flips or give up, then release
	task automatic press();
		logic old;
		int   k;
		old = heater_on;
		push <= 1'b1;
		for (k = 0; k < 40 && heater_on === old; k++) @(posedge clock);
		push <= 1'b0;
	endtask : press
	task automatic t_reset();
		cyc(2);
		chk_out(1'b0);
		chk("long_used", 1'b0, long_used);
		reset <= 1'b0;
		cyc(1);
	endtask : t_reset
	task automatic t_toggle();
		ignition_on <= 1'b1;
		cyc(4);
		press();
		cyc(16);
		chk_out(1'b1);
		press();
		cyc(16);
		chk_out(1'b0);
	endtask : t_toggle
	// Glitch shorter than the filter span
	task automatic t_bounce();
		push <= 1'b1;
		cyc(3);
		push <= 1'b0;
		cyc(20);
		chk_out(1'b0);
	endtask : t_bounce
	task automatic t_ign();
		ignition_on <= 1'b0;
		cyc(4);
		press();
		cyc(16);
		chk_out(1'b0);
		ignition_on <= 1'b1;
		cyc(4);
		press();
		ignition_on <= 1'b0;
		cyc(2);
		chk_out(1'b0);
	endtask : t_ign
	// Long then short interval, long again on a fresh key cycle
	task automatic t_timer();
		ignition_on <= 1'b1;
		cyc(4);
		press();
		cyc(70);
		chk_out(1'b1);
		chk("long_used", 1'b0, long_used);
		cyc(18);
		chk_out(1'b0);
		chk("long_used", 1'b1, long_used);
		press();
		cyc(32);
		chk_out(1'b1);
		cyc(16);
		chk_out(1'b0);
		ignition_on <= 1'b0;
		cyc(4);
		chk("long_used", 1'b0, long_used);
		ignition_on <= 1'b1;
		cyc(4);
		press();
		cyc(70);
		chk_out(1'b1);
	endtask : t_timer
	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	// Run is about 400 cycles; limit gives tenfold margin
	initial begin
		#200us;
		n_fail++;
		complete_run();
	end
	initial begin
		t_reset();
		t_toggle();
		t_bounce();
		t_ign();
		t_timer();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
